/* plac_pkg.sv */
// Package of constants for the pointer-add and computed-call execution block
package plac_pkg;
    localparam logic [7:0] ADD_PTR_UPPER = 8'hE8;
    localparam logic [15:0] CALL_ACC_OPCODE = 16'h0014;
    localparam logic [1:0] SEL_RETURN = 2'h3;
    localparam logic [20:0] RETURN_STEP = 21'h00_0002;
    localparam int PTR_W = 12;
    localparam int PC_W = 21;
    localparam logic [11:0] PTR_RESET = 12'h000;
    localparam logic [20:0] PC_RESET = 21'h00_0000;
    typedef enum logic [1:0] {PLAC_EXEC, PLAC_FLUSH} plac_state_e;
endpackage

/* plac_exec.sv */
// Execution logic for pointer add, add-and-return and computed call
module plac_exec
    import plac_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Configuration
    input wire logic extendedSetEnable,
    // Fetched instruction
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    // Core state read
    input wire logic [20:0] programCounter,
    input wire logic [7:0] accumulatorRegister,
    input wire logic [7:0] programCounterLatchHigh,
    input wire logic [4:0] programCounterLatchUpper,
    input wire logic [20:0] returnStackTop,
    // Pointer write results
    output logic [11:0] indirectPointer0,
    output logic [11:0] indirectPointer1,
    output logic [11:0] stackFramePointer,
    // Program flow
    output logic pcLoad,
    output logic [20:0] pcValue,
    output logic stackPush,
    output logic [20:0] stackPushValue,
    output logic stackPop,
    output logic flushNop
);
    // Execute or flush; the flush state swallows the slot behind a jump
    plac_state_e state;
    plac_state_e next_state;

    // Pointer sum over full width, carry goes into high half
    // Wraps at 4096, so a carry out of the top bit is lost on purpose
    function automatic logic [11:0] ptrAdd(input logic [11:0] p, input logic [5:0] k);
        ptrAdd = p + {6'h00, k};
    endfunction

    // Decode, gated by enable and by the flush cycle
    wire logic live = instrValid && extendedSetEnable && (state == PLAC_EXEC);
    wire logic isAdd = live && (instrWord[15:8] == ADD_PTR_UPPER);
    wire logic [1:0] ptrSel = instrWord[7:6];
    wire logic [5:0] literal = instrWord[5:0];
    wire logic isAddRet = isAdd && (ptrSel == SEL_RETURN);
    wire logic isCall = live && (instrWord == CALL_ACC_OPCODE);
    wire logic [20:0] callTarget = {programCounterLatchUpper, programCounterLatchHigh,
        accumulatorRegister};
    // Accumulator, flags and bank select have no write port here at all
    wire logic [20:0] retAddr = programCounter + RETURN_STEP;

    // Held outputs keep their last value unless their instruction fires;
    // naming the next values keeps the flow register block short
    wire logic twoCycleOp = isAddRet || isCall;
    wire logic [20:0] next_pcValue = isCall ? callTarget
        : (isAddRet ? returnStackTop : pcValue);
    wire logic [20:0] next_stackPushValue = isCall ? retAddr : stackPushValue;

    // Two-cycle ops spend their second cycle as a no-operation
    always_comb begin
        next_state = PLAC_EXEC;
        if (isAddRet || isCall) begin
            next_state = PLAC_FLUSH;
        end
    end

    // Pointer registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            indirectPointer0 <= PTR_RESET;
            indirectPointer1 <= PTR_RESET;
            stackFramePointer <= PTR_RESET;
        end else if (isAdd) begin
            unique case (ptrSel)
                2'h0: indirectPointer0 <= ptrAdd(indirectPointer0, literal);
                2'h1: indirectPointer1 <= ptrAdd(indirectPointer1, literal);
                default: stackFramePointer <= ptrAdd(stackFramePointer, literal);
            endcase
        end
    end

    // Flow control outputs, registered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= PLAC_EXEC;
            pcLoad <= 1'b0;
            pcValue <= PC_RESET;
            stackPush <= 1'b0;
            stackPushValue <= PC_RESET;
            stackPop <= 1'b0;
            flushNop <= 1'b0;
        end else begin
            state <= next_state;
            pcLoad <= twoCycleOp;
            pcValue <= next_pcValue;
            stackPush <= isCall;
            stackPushValue <= next_stackPushValue;
            stackPop <= isAddRet;
            flushNop <= twoCycleOp;
        end
    end

    // Checks
    addret_flow_a: assert property (@(posedge ref_clk) disable iff (rst)
        isAddRet |=> pcLoad && stackPop && flushNop && pcValue == $past(returnStackTop))
        else $error("add-and-return flow wrong");
    call_flow_a: assert property (@(posedge ref_clk) disable iff (rst)
        isCall |=> stackPush && stackPushValue == $past(programCounter) + 21'h00_0002)
        else $error("call push wrong");
    call_target_a: assert property (@(posedge ref_clk) disable iff (rst)
        isCall |=> pcValue == {$past(programCounterLatchUpper),
            $past(programCounterLatchHigh), $past(accumulatorRegister)})
        else $error("call target wrong");
    flush_nop_a: assert property (@(posedge ref_clk) disable iff (rst)
        flushNop |-> !isAdd && !isCall)
        else $error("flush cycle executed");
    frame_add_a: assert property (@(posedge ref_clk) disable iff (rst)
        isAddRet |=> stackFramePointer == $past(stackFramePointer) + {6'h00, $past(literal)}
            && $stable(indirectPointer0) && $stable(indirectPointer1))
        else $error("frame add wrong");
    ptr_add_a: assert property (@(posedge ref_clk) disable iff (rst)
        isAdd && ptrSel == 2'h0 |=> indirectPointer0 ==
            $past(indirectPointer0) + {6'h00, $past(literal)})
        else $error("pointer add wrong");
    disabled_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        !extendedSetEnable |=> !pcLoad && !stackPush)
        else $error("acted while disabled");
    one_cycle_add_a: assert property (@(posedge ref_clk) disable iff (rst)
        isAdd && !isAddRet |=> !flushNop)
        else $error("plain add stalled");

    // Second and third pointers take the same sum as the first
    ptr1_add_a: assert property (@(posedge ref_clk) disable iff (rst)
        isAdd && ptrSel == 2'h1 |=> indirectPointer1 ==
            $past(indirectPointer1) + {6'h00, $past(literal)})
        else $error("second pointer add wrong");
    ptr2_add_a: assert property (@(posedge ref_clk) disable iff (rst)
        isAdd && ptrSel == 2'h2 |=> stackFramePointer ==
            $past(stackFramePointer) + {6'h00, $past(literal)})
        else $error("third pointer add wrong");

    // A plain add touches only the pointer it names
    add_only_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        isAdd && ptrSel == 2'h0 |=> $stable(indirectPointer1) && $stable(stackFramePointer))
        else $error("add to first pointer moved another");
    add_only_one_a: assert property (@(posedge ref_clk) disable iff (rst)
        isAdd && ptrSel == 2'h1 |=> $stable(indirectPointer0) && $stable(stackFramePointer))
        else $error("add to second pointer moved another");

    // Add-and-return pops the return stack and never pushes it
    addret_no_push_a: assert property (@(posedge ref_clk) disable iff (rst)
        isAddRet |=> !stackPush)
        else $error("add-and-return pushed");
    pop_source_a: assert property (@(posedge ref_clk) disable iff (rst)
        stackPop |-> $past(isAddRet))
        else $error("pop without add-and-return");

    // Calls never pop and leave every pointer alone; there is no write path
    // for accumulator, flags or bank select, so pointers are what is left
    call_no_pop_a: assert property (@(posedge ref_clk) disable iff (rst)
        isCall |=> !stackPop)
        else $error("call popped");
    push_source_a: assert property (@(posedge ref_clk) disable iff (rst)
        stackPush |-> $past(isCall))
        else $error("push without call");
    call_ptrs_a: assert property (@(posedge ref_clk) disable iff (rst)
        isCall |=> $stable(indirectPointer0) && $stable(indirectPointer1)
            && $stable(stackFramePointer))
        else $error("call changed a pointer");

    // Upper bytes of the call target come from the two latches
    call_upper_a: assert property (@(posedge ref_clk) disable iff (rst)
        isCall |=> pcValue[20:8] == {$past(programCounterLatchUpper),
            $past(programCounterLatchHigh)})
        else $error("call upper target wrong");
    // The low byte is the accumulator, whatever the old low byte was
    call_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        isCall |=> pcValue[7:0] == $past(accumulatorRegister))
        else $error("call low target wrong");

    // Pulses last one cycle; a new op cannot start in the slot behind them
    flush_once_a: assert property (@(posedge ref_clk) disable iff (rst)
        flushNop |=> !flushNop && !pcLoad && !stackPush && !stackPop)
        else $error("no-operation cycle repeated");
    flush_state_a: assert property (@(posedge ref_clk) disable iff (rst)
        flushNop |-> state == PLAC_FLUSH)
        else $error("no-operation pulse outside flush state");
    load_flush_a: assert property (@(posedge ref_clk) disable iff (rst)
        pcLoad |-> flushNop)
        else $error("load without no-operation cycle");
    flush_ptrs_a: assert property (@(posedge ref_clk) disable iff (rst)
        state == PLAC_FLUSH |=> $stable(indirectPointer0) && $stable(indirectPointer1)
            && $stable(stackFramePointer))
        else $error("pointer changed in no-operation cycle");

    // Held targets change only when their instruction fires
    pc_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !isCall && !isAddRet |=> $stable(pcValue))
        else $error("target changed without a jump");
    push_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !isCall |=> $stable(stackPushValue))
        else $error("return address changed without a call");

    // With the enable clear nothing moves; an empty slot is idle as well
    disabled_ptrs_a: assert property (@(posedge ref_clk) disable iff (rst)
        !extendedSetEnable |=> $stable(indirectPointer0) && $stable(indirectPointer1)
            && $stable(stackFramePointer) && !stackPop && !flushNop)
        else $error("pointer moved while disabled");
    invalid_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        !instrValid |=> !pcLoad && $stable(indirectPointer0) && $stable(indirectPointer1)
            && $stable(stackFramePointer))
        else $error("acted on an empty slot");
endmodule // plac_exec

/* tb_pointer_literal_add_and_indirect_call.sv */
// Self-checking bench for the pointer-add and computed-call block
module tb_pointer_literal_add_and_indirect_call;
    timeunit 1ns;
    timeprecision 1ns;
    import plac_pkg::*;
    // Stimulus and observed outputs
    logic ref_clk = 0, rst = 1, en = 0, vld = 0;
    logic [15:0] iw = 0;
    logic [20:0] pc = 0, return_stack_top = 0, pcV, pushV;
    logic [7:0] acc = 0, lh = 0;
    logic [4:0] lu = 0;
    logic [11:0] ip0, ip1, sfp;
    logic pcLoad, push, pop, flushNop;
    logic [31:0] r;
    int seed = 26, n_fail = 0, n_checks = 0, cyc = 0, k, s;
    int p[3];
    plac_exec uut (.ref_clk(ref_clk), .rst(rst), .extendedSetEnable(en), .instrValid(vld),
        .instrWord(iw), .programCounter(pc), .accumulatorRegister(acc),
        .programCounterLatchHigh(lh), .programCounterLatchUpper(lu), .returnStackTop(return_stack_top),
        .indirectPointer0(ip0), .indirectPointer1(ip1), .stackFramePointer(sfp),
        .pcLoad(pcLoad), .pcValue(pcV), .stackPush(push), .stackPushValue(pushV),
        .stackPop(pop), .flushNop(flushNop));
    // Clock and hang guard; a hung run still ends in the verdict
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            results();
        end
    end
    task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One cycle: random core state, one instruction, sample after the edge
    task automatic go(input logic [15:0] w, input logic v);
        r = $random(seed);
        {lu, lh, acc} = r[20:0];
        r = $random(seed);
        return_stack_top = r[20:0];
        r = $random(seed);
        pc = r[20:0];
        iw = w;
        vld = v;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic ptrs();
        chk(21'(ip0), 21'(p[0]));
        chk(21'(ip1), 21'(p[1]));
        chk(21'(sfp), 21'(p[2]));
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence; inputs always change 1 ns after the rising edge
    initial begin
        p = '{0, 0, 0};
        repeat (10) @(posedge ref_clk);
        #1 rst = 0;
        ptrs();
        chk(21'({pcLoad, push, pop, flushNop}), 21'h0);
        chk(pcV, 21'h0);
        chk(pushV, 21'h0);
        go(16'hE8C5, 1);
        ptrs();
        chk(21'(pcLoad), 21'h0);
        go(CALL_ACC_OPCODE, 1);
        chk(21'({pcLoad, push, pop, flushNop}), 21'h0);
        $display("test reset and disabled done");
        en = 1;
        go(16'hE8C5, 0);
        ptrs();
        chk(21'({pcLoad, pop, flushNop}), 21'h0);
        for (int i = 0; i < 30; i++) begin
            r = $random(seed);
            s = i % 3;
            k = (i < 15) ? 63 : int'(r[5:0]);
            go({ADD_PTR_UPPER, 2'(s), 6'(k)}, 1);
            p[s] = (p[s] + k) % 4096;
            ptrs();
            chk(21'(flushNop), 0);
        end
        $display("test pointer adds done");
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            k = int'(r[5:0]);
            go({ADD_PTR_UPPER, SEL_RETURN, 6'(k)}, 1);
            p[2] = (p[2] + k) % 4096;
            ptrs();
            chk(21'({pcLoad, pop, flushNop, push}), 21'hE);
            chk(pcV, return_stack_top);
            go(16'hE801, 1);
            ptrs();
            chk(21'({pcLoad, pop, flushNop}), 21'h0);
            go(CALL_ACC_OPCODE, 1);
            chk(21'({push, pcLoad, flushNop, pop}), 21'hE);
            chk(pushV, pc + 21'h2);
            chk(pcV, {lu, lh, acc});
            go(CALL_ACC_OPCODE, 1);
            chk(21'({push, pcLoad, flushNop}), 21'h0);
        end
        $display("test return and call done");
        rst = 1;
        go(16'hE805, 1);
        rst = 0;
        p = '{0, 0, 0};
        ptrs();
        chk(21'({pcLoad, push, pop, flushNop}), 21'h0);
        go(16'hE805, 1);
        p[0] = 5;
        ptrs();
        $display("test second reset done");
        results();
    end
endmodule // tb_pointer_literal_add_and_indirect_call
